// ==== qmw_pkg.sv ====
`default_nettype none
package qmw_pkg;
	localparam int          CLK_PERIOD_NS  = 40;
	localparam int          TIMER_W        = 24;
	localparam int          MEM_DEPTH      = 384;
	localparam logic [6:0]  DEV_ADDR       = 7'h50;
	localparam logic [2:0]  MAX_WBYTES     = 3'h4;
	localparam logic [3:0]  BYTE_BITS      = 4'h8;
	localparam logic [7:0]  ID_ADDR        = 8'h00;
	localparam logic [7:0]  STATUS_ADDR    = 8'h02;
	localparam logic [7:0]  FLAG_ADDR      = 8'h03;
	localparam logic [7:0]  RW_FIRST       = 8'h56;
	localparam logic [7:0]  PAGE_SEL_ADDR  = 8'h7F;
	localparam logic [7:0]  UPPER_BASE     = 8'h80;
	localparam logic [7:0]  PAGE_00        = 8'h00;
	localparam logic [7:0]  PAGE_03        = 8'h03;
	localparam logic [1:0]  SEG_LOWER      = 2'h0;
	localparam logic [1:0]  SEG_PAGE_00    = 2'h1;
	localparam logic [1:0]  SEG_PAGE_03    = 2'h2;
	localparam logic        FLAT_MEM       = 1'b0;
	localparam logic        DATA_NOT_READY = 1'b0;
	localparam logic [4:0]  STATUS_RSVD    = 5'h00;

	typedef enum logic [2:0] {
		P_IDLE,
		P_DEV,
		P_MADDR,
		P_WDATA,
		P_RDATA,
		P_HOSTACK,
		P_IGNORE
	} qmw_phase_e;

	typedef struct packed {
		qmw_phase_e           phase;
		logic                 scl_q;
		logic                 sda_q;
		logic [3:0]           bitcnt;
		logic [7:0]           shreg;
		logic                 in_ack;
		logic                 ack_ok;
		logic                 rd;
		logic                 sda_oe;
		logic                 sda_out;
		logic [7:0]           maddr;
		logic [7:0]           wbase;
		logic [2:0]           wcnt;
		logic [3:0][7:0]      wbuf;
		logic                 busy;
		logic [TIMER_W-1:0]   timer;
		logic [2:0]           cidx;
		logic [7:0]           page;
		logic [7:0]           flags;
		logic                 irq_n;
	} qmw_state_s;
endpackage
`default_nettype wire

// ==== qmw_target.sv ====
`timescale 1ns/1ns
`default_nettype none
module qmw_target #(
	parameter int         WR_TIME_NS = 10000000,
	parameter logic [7:0] ID_CODE    = 8'h5A
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// Management serial bus
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Module pins
	input  wire logic       module_select_n,
	input  wire logic       module_reset_n,
	output logic            interrupt_out_n,
	// Flag events from the module
	input  wire logic [7:0] flag_event
);
	// ID_CODE is an arbitrary neutral value.
	localparam int WR_CYC_RAW = (WR_TIME_NS + qmw_pkg::CLK_PERIOD_NS - 1) / qmw_pkg::CLK_PERIOD_NS;
	localparam int WR_CYC     = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;

	qmw_pkg::qmw_state_s st;
	qmw_pkg::qmw_state_s next_st;
	logic [7:0]          mem [0:qmw_pkg::MEM_DEPTH-1];
	logic                mem_we;
	logic [8:0]          mem_idx;
	logic [7:0]          mem_wd;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_c;
	logic                stop_c;
	logic                rx_last;
	logic [7:0]          rx;
	logic [7:0]          rd_byte;
	logic                load;
	logic                clr_flags;
	logic [9:0]          wmap;
	logic [9:0]          rmap;
	logic [7:0]          caddr;
	logic [7:0]          cur_wbyte;

	// Returns {valid, index} of the backing store for an address and page.
	function automatic logic [9:0] map_addr(input logic [7:0] a, input logic [7:0] pg);
		logic [9:0] r;
		r = '0;
		if (a < qmw_pkg::UPPER_BASE) begin
			r = {a >= qmw_pkg::RW_FIRST && a != qmw_pkg::PAGE_SEL_ADDR,
				qmw_pkg::SEG_LOWER, a[6:0]};
		end else if (pg == qmw_pkg::PAGE_00) begin
			r = {1'b1, qmw_pkg::SEG_PAGE_00, a[6:0]};
		end else if (pg == qmw_pkg::PAGE_03) begin
			r = {1'b1, qmw_pkg::SEG_PAGE_03, a[6:0]};
		end
		return r;
	endfunction

	assign scl_rise = scl_in & ~st.scl_q;
	assign scl_fall = ~scl_in & st.scl_q;
	assign start_c  = scl_in & st.scl_q & st.sda_q & ~sda_in;
	assign stop_c   = scl_in & st.scl_q & ~st.sda_q & sda_in;
	assign rx       = {st.shreg[6:0], sda_in};
	assign rx_last  = !st.busy && scl_rise && !st.in_ack
		&& st.bitcnt == qmw_pkg::BYTE_BITS - 4'h1
		&& (st.phase == qmw_pkg::P_DEV || st.phase == qmw_pkg::P_MADDR
		|| st.phase == qmw_pkg::P_WDATA);
	assign caddr    = st.wbase + {5'h00, st.cidx};
	assign wmap     = map_addr(caddr, st.page);
	assign rmap     = map_addr(st.maddr, st.page);
	assign cur_wbyte = st.wbuf[st.cidx[1:0]];

	always_comb begin
		if (st.maddr == qmw_pkg::ID_ADDR) begin
			rd_byte = ID_CODE;
		end else if (st.maddr == qmw_pkg::STATUS_ADDR) begin
			rd_byte = {qmw_pkg::STATUS_RSVD, qmw_pkg::FLAT_MEM, st.irq_n,
				qmw_pkg::DATA_NOT_READY};
		end else if (st.maddr == qmw_pkg::FLAG_ADDR) begin
			rd_byte = st.flags;
		end else if (st.maddr == qmw_pkg::PAGE_SEL_ADDR) begin
			rd_byte = st.page;
		end else if (rmap[9]) begin
			rd_byte = mem[rmap[8:0]];
		end else begin
			rd_byte = '0;
		end
	end

	always_comb begin
		next_st   = st;
		mem_we    = 1'b0;
		mem_idx   = '0;
		mem_wd    = '0;
		load      = 1'b0;
		clr_flags = 1'b0;
		next_st.scl_q = scl_in;
		next_st.sda_q = sda_in;
		if (st.busy) begin
			next_st.phase  = qmw_pkg::P_IDLE;
			next_st.sda_oe = 1'b0;
			next_st.in_ack = 1'b0;
			if (st.cidx < st.wcnt) begin
				next_st.cidx = st.cidx + 3'h1;
				if (caddr == qmw_pkg::PAGE_SEL_ADDR) begin
					next_st.page = cur_wbyte;
				end else begin
					mem_we  = wmap[9];
					mem_idx = wmap[8:0];
					mem_wd  = cur_wbyte;
				end
			end
			if (st.timer == '0) begin
				next_st.busy = 1'b0;
				next_st.wcnt = '0;
			end else begin
				next_st.timer = st.timer - 1'b1;
			end
		end else if (start_c) begin
			next_st.phase  = qmw_pkg::P_DEV;
			next_st.bitcnt = '0;
			next_st.wcnt   = '0;
			next_st.in_ack = 1'b0;
			next_st.sda_oe = 1'b0;
		end else if (stop_c) begin
			if (st.phase == qmw_pkg::P_WDATA && st.wcnt != '0 && !st.in_ack) begin
				next_st.busy  = 1'b1;
				next_st.timer = qmw_pkg::TIMER_W'(WR_CYC - 1);
				next_st.cidx  = '0;
			end else begin
				next_st.wcnt = '0;
			end
			next_st.phase  = qmw_pkg::P_IDLE;
			next_st.in_ack = 1'b0;
			next_st.sda_oe = 1'b0;
		end else if (scl_rise) begin
			case (st.phase)
				qmw_pkg::P_DEV, qmw_pkg::P_MADDR, qmw_pkg::P_WDATA: begin
					if (!st.in_ack) begin
						next_st.shreg  = rx;
						next_st.bitcnt = st.bitcnt + 4'h1;
					end
					if (rx_last) begin
						next_st.ack_ok = 1'b1;
						if (st.phase == qmw_pkg::P_DEV) begin
							next_st.ack_ok = rx[7:1] == qmw_pkg::DEV_ADDR
								&& !module_select_n;
							next_st.rd     = rx[0];
						end else if (st.phase == qmw_pkg::P_MADDR) begin
							next_st.maddr = rx;
							next_st.wbase = rx;
						end else if (st.wcnt < qmw_pkg::MAX_WBYTES) begin
							next_st.wbuf[st.wcnt[1:0]] = rx;
							next_st.wcnt  = st.wcnt + 3'h1;
							next_st.maddr = st.maddr + 8'h01;
						end else begin
							next_st.ack_ok = 1'b0;
							next_st.wcnt   = '0;
						end
					end
				end
				qmw_pkg::P_RDATA: begin
					next_st.bitcnt = st.bitcnt + 4'h1;
				end
				qmw_pkg::P_HOSTACK: begin
					if (sda_in) begin
						next_st.phase = qmw_pkg::P_IGNORE;
					end else begin
						next_st.ack_ok = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (st.phase)
				qmw_pkg::P_DEV, qmw_pkg::P_MADDR, qmw_pkg::P_WDATA: begin
					if (st.in_ack) begin
						next_st.in_ack = 1'b0;
						next_st.sda_oe = 1'b0;
						if (st.phase == qmw_pkg::P_DEV && st.rd) begin
							load = 1'b1;
						end else if (st.phase == qmw_pkg::P_DEV) begin
							next_st.phase = qmw_pkg::P_MADDR;
						end else begin
							next_st.phase = qmw_pkg::P_WDATA;
						end
					end else if (st.bitcnt == qmw_pkg::BYTE_BITS) begin
						next_st.bitcnt = '0;
						if (st.ack_ok) begin
							next_st.in_ack = 1'b1;
							next_st.sda_oe = 1'b1;
						end else begin
							next_st.phase = qmw_pkg::P_IGNORE;
						end
					end
				end
				qmw_pkg::P_RDATA: begin
					if (st.bitcnt == qmw_pkg::BYTE_BITS) begin
						next_st.sda_oe = 1'b0;
						next_st.ack_ok = 1'b0;
						next_st.phase  = qmw_pkg::P_HOSTACK;
					end else begin
						next_st.shreg  = {st.shreg[6:0], 1'b0};
						next_st.sda_oe = ~st.shreg[6];
					end
				end
				qmw_pkg::P_HOSTACK: begin
					load = st.ack_ok;
				end
				default: begin
				end
			endcase
		end
		if (load) begin
			next_st.phase  = qmw_pkg::P_RDATA;
			next_st.shreg  = rd_byte;
			next_st.sda_oe = ~rd_byte[7];
			next_st.bitcnt = '0;
			next_st.maddr  = st.maddr + 8'h01;
			clr_flags      = st.maddr == qmw_pkg::FLAG_ADDR;
		end
		// A new event wins over a clear by read in the same cycle.
		next_st.flags = (st.flags & ~{8{clr_flags}}) | flag_event;
		if (!module_reset_n) begin
			next_st.flags = '0;
		end
		next_st.irq_n = ~|next_st.flags;
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st       <= '0;
			st.phase <= qmw_pkg::P_IDLE;
			st.scl_q <= 1'b1;
			st.sda_q <= 1'b1;
			st.irq_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge mclk) begin
		if (mem_we) begin
			mem[mem_idx] <= mem_wd;
		end
	end

	assign sda_out         = st.sda_out;
	assign sda_oe          = st.sda_oe;
	assign interrupt_out_n = st.irq_n;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence seq_write_stop;
		!st.busy && stop_c && st.phase == qmw_pkg::P_WDATA && st.wcnt != '0 && !st.in_ack;
	endsequence

	sequence seq_rstart_in_write;
		!st.busy && start_c && st.phase == qmw_pkg::P_WDATA;
	endsequence

	sequence seq_maddr_taken;
		rx_last && st.phase == qmw_pkg::P_MADDR;
	endsequence

	AST_BUSY_SILENT: assert property (st.busy |-> !st.sda_oe)
		else $error("Bus driven during write cycle");
	AST_STOP_COMMITS: assert property (seq_write_stop |=> st.busy && st.cidx == '0)
		else $error("Valid STOP did not start write cycle");
	AST_RSTART_ABORT: assert property (seq_rstart_in_write |=> st.wcnt == '0 && !st.busy)
		else $error("Repeated START did not discard write");
	AST_MADDR_ACK: assert property (seq_maddr_taken |=> st.ack_ok ##[1:1000] st.sda_oe)
		else $error("Memory address byte not acknowledged");
	AST_WCNT_LIMIT: assert property (st.wcnt <= qmw_pkg::MAX_WBYTES)
		else $error("More than four bytes buffered");
	AST_ADDR_ADVANCE: assert property (rx_last && st.phase == qmw_pkg::P_WDATA
		&& st.wcnt < qmw_pkg::MAX_WBYTES |=> st.maddr == $past(st.maddr) + 8'h01)
		else $error("Address did not advance after data byte");
	AST_FLAG_SET: assert property (flag_event[0] && module_reset_n |=> st.flags[0])
		else $error("Flag event not latched");
	AST_IRQ_FOLLOWS: assert property (st.flags != '0 |-> !interrupt_out_n)
		else $error("Interrupt not asserted with latched flag");
	AST_PAGE_WRITE: assert property (st.busy && st.cidx < st.wcnt
		&& caddr == qmw_pkg::PAGE_SEL_ADDR |=> st.page == $past(cur_wbyte))
		else $error("Page select byte not written");
	AST_NO_POLL_ACK: assert property (st.busy |=> st.phase == qmw_pkg::P_IDLE && !st.in_ack)
		else $error("Address taken during write cycle");
endmodule
`default_nettype wire

// ==== qmw_host.sv ====
`timescale 1ns/1ns
`default_nettype none
// Bus master model. Each SCL level is held several mclk so the target sees every edge.
module qmw_host (
	input  wire logic mclk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic start();
		sda_drv <= 1'b1;
		tk(2);
		scl <= 1'b1;
		tk(3);
		sda_drv <= 1'b0;
		tk(3);
		scl <= 1'b0;
		tk(2);
	endtask
	task automatic stop();
		sda_drv <= 1'b0;
		tk(2);
		scl <= 1'b1;
		tk(3);
		sda_drv <= 1'b1;
		tk(3);
	endtask
	task automatic bit_io(input logic b, output logic s);
		sda_drv <= b;
		tk(2);
		scl <= 1'b1;
		tk(3);
		s = sda_line;
		tk(1);
		scl <= 1'b0;
		tk(2);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(!more, s);
	endtask
endmodule
`default_nettype wire

// ==== module_mgmt_serial_write_paging_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module module_mgmt_serial_write_paging_tb;
	logic        mclk;
	logic        rstn;
	logic        scl;
	logic        host_sda;
	wire logic   sda_line;
	logic        sda_out;
	logic        sda_oe;
	logic        module_select_n;
	logic        module_reset_n;
	logic        interrupt_out_n;
	logic [7:0]  flag_event;
	logic [31:0] q;
	logic        ack;
	int          n_fail;
	int          cmp_count;

	assign sda_line = host_sda & (~sda_oe | sda_out);

	qmw_host i_host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda));

	// Write cycle shortened to 100 mclk; busy then lasts 100 mclk.
	qmw_target #(.WR_TIME_NS(4000)) i_dut (
		.mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .module_select_n(module_select_n),
		.module_reset_n(module_reset_n), .interrupt_out_n(interrupt_out_n),
		.flag_event(flag_event)
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic summarize();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic addr_phase(input logic [7:0] a);
		i_host.start();
		i_host.wbyte(8'hA0, ack);
		chk("dev_ack", ack, 1);
		i_host.wbyte(a, ack);
		chk("maddr_ack", ack, 1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [39:0] d, input int n, input logic fin);
		addr_phase(a);
		for (int k = 0; k < n; k++) begin
			i_host.wbyte(d[39-8*k -: 8], ack);
			chk("data_ack", ack, k < 4);
		end
		if (!fin) i_host.start();
		i_host.stop();
		if (fin && n < 5) repeat (110) @(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, input int n);
		logic [7:0] b;
		q = '0;
		addr_phase(a);
		i_host.start();
		i_host.wbyte(8'hA1, ack);
		chk("rd_ack", ack, 1);
		for (int k = 0; k < n; k++) begin
			i_host.rbyte(k < n - 1, b);
			q = {q[23:0], b};
		end
		i_host.stop();
	endtask

	task automatic poll(input logic exp);
		i_host.start();
		i_host.wbyte(8'hA0, ack);
		chk("poll", ack, exp);
		i_host.stop();
	endtask

	task automatic t_write1();
		addr_phase(8'h56);
		i_host.wbyte(8'hC3, ack);
		chk("data_ack", ack, 1);
		i_host.stop();
		poll(1'b0);
		repeat (20) @(posedge mclk);
		poll(1'b1);
		rd(8'h56, 1);
		chk("byte_write", q, 32'h0000_00C3);
	endtask

	task automatic t_seq();
		wr(8'h60, 40'h11_2233_4400, 4, 1'b1);
		rd(8'h60, 4);
		chk("seq_write", q, 32'h1122_3344);
		wr(8'h60, 40'hAA_BBCC_DDEE, 5, 1'b1);
		wr(8'h60, 40'h99_0000_0000, 1, 1'b0);
		rd(8'h60, 4);
		chk("discard", q, 32'h1122_3344);
	endtask

	task automatic t_page();
		logic [7:0] pg [3];
		logic [7:0] dv [3];
		logic [7:0] ex [3];
		pg = '{8'h03, 8'h00, 8'h01};
		dv = '{8'h5A, 8'hA5, 8'h77};
		ex = '{8'h5A, 8'hA5, 8'h00};
		for (int k = 0; k < 3; k++) begin
			wr(8'h7F, {pg[k], 32'h0000_0000}, 1, 1'b1);
			wr(8'h80, {dv[k], 32'h0000_0000}, 1, 1'b1);
		end
		for (int k = 0; k < 3; k++) begin
			wr(8'h7F, {pg[k], 32'h0000_0000}, 1, 1'b1);
			rd(8'h7F, 2);
			chk("page", q, {16'h0000, pg[k], ex[k]});
		end
		rd(8'h00, 4);
		chk("lower", q, 32'h5A00_0200);
	endtask

	task automatic t_flags();
		flag_event <= 8'h08;
		@(posedge mclk);
		flag_event <= 8'h00;
		repeat (2) @(posedge mclk);
		chk("irq_set", interrupt_out_n, 0);
		rd(8'h02, 2);
		chk("flags", q, 32'h0000_0008);
		rd(8'h03, 1);
		chk("flag_clr", {q[7:0], interrupt_out_n}, 32'h0000_0001);
		flag_event <= 8'h81;
		@(posedge mclk);
		flag_event <= 8'h00;
		module_reset_n <= 1'b0;
		@(posedge mclk);
		module_reset_n <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("mod_rst", interrupt_out_n, 1);
	endtask

	task automatic t_select();
		module_select_n <= 1'b1;
		poll(1'b0);
		module_select_n <= 1'b0;
		i_host.start();
		i_host.wbyte(8'hA4, ack);
		chk("other_addr", ack, 0);
		i_host.stop();
	endtask

	initial begin
		n_fail = 0;
		cmp_count = 0;
		rstn = 1'b0;
		module_select_n = 1'b0;
		module_reset_n = 1'b1;
		flag_event = 8'h00;
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("rst_out", {sda_out, sda_oe, interrupt_out_n}, 32'h0000_0001);
		t_write1();
		t_seq();
		t_page();
		t_flags();
		t_select();
		summarize();
	end

	initial begin
		repeat (60000) @(posedge mclk);
		n_fail++;
		summarize();
	end
endmodule
`default_nettype wire
